// *** hw/sesmi_top.sv ***
// Sleep entry sequencer with SMI status group and register port.
// Assumes a 100 MHz core clock and a free running 32 kHz RTC clock pin.
module sesmi_top
   import sesmi_pkg::*;
#(
   parameter int RTC_MIN = sesmi_pkg::RTC_MIN_CYCLES,
   parameter int RTC_MAX = sesmi_pkg::RTC_MAX_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // RTC clock pin
   input wire logic rtc_clk_32k,
   // SMI source pins
   input wire logic gpio_pin_34,
   input wire logic gpio_pin_35,
   input wire logic gpio_pin_36,
   input wire logic gpio_pin_37,
   input wire logic keyboard_port_pin,
   input wire logic gpio_pin_62,
   // Power supply on, open drain
   input wire logic power_supply_on_n_in,
   output logic power_supply_on_n_out,
   output logic power_supply_on_n_oe_n,
   // Sleep state and interrupt
   output logic [2:0] sleep_state_out,
   output logic sleeping,
   output logic smi_irq
);
   import sesmi_pkg::*;

   localparam int MIN_C = RTC_MIN;
   localparam int MAX_C = RTC_MAX + SYNC_SLACK_CYCLES;

   initial begin
      if (RTC_MIN < 1 || RTC_MAX < RTC_MIN)
         $error("sesmi_top: bad RTC cycle counts");
   end

   logic rtc_s;
   logic rtc_d;
   logic rtc_rise;
   logic [1:0] warm;
   logic [5:0] src_s;
   logic [5:0] src_d;
   logic [5:0] src_rise;
   logic pin_s;
   logic [2:0] sleep_type_field;
   logic [2:0] type_latched;
   logic sleep_trap_select;
   logic [7:0] smi_status_group7;
   logic [7:0] smi_enable_group7;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic trap_pend;
   logic slp_write;
   logic wr_ctrl;
   logic wr_sts;
   logic sleep_write_smi_flag;
   logic [7:0] next_rdata;
   sesmi_state_type state;

   // Pin synchronisers
   sesmi_sync #(.WIDTH(8)) u_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .async_in({power_supply_on_n_in, rtc_clk_32k, gpio_pin_62,
         keyboard_port_pin, gpio_pin_37, gpio_pin_36, gpio_pin_35,
         gpio_pin_34}),
      .sync_out({pin_s, rtc_s, src_s})
   );

   // Edge detection on synchronised levels
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rtc_d <= 1'b0;
         src_d <= 6'h00;
         warm <= 2'h0;
      end else begin
         rtc_d <= rtc_s;
         src_d <= src_s;
         warm <= (warm == 2'h3) ? warm : warm + 2'h1;
      end
   end

   // No edge until both flops hold real pin samples after reset
   assign rtc_rise = rtc_s & ~rtc_d & (warm == 2'h3);
   assign src_rise = src_s & ~src_d & {6{warm == 2'h3}};

   // Write decode
   assign wr_ctrl = reg_wr && (reg_addr == SLEEP_CONTROL_ADDR);
   assign wr_sts = reg_wr && (reg_addr == SMI_STATUS_ADDR);
   assign slp_write = wr_ctrl && reg_wdata[SLEEP_ENABLE_BIT];
   assign sleep_write_smi_flag = smi_status_group7[STS_SLEEP_WRITE];

   // Sleep type field and trap select
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sleep_type_field <=
            SLEEP_CONTROL_RESET[SLEEP_TYPE_MSB:SLEEP_TYPE_LSB];
      end else if (wr_ctrl) begin
         sleep_type_field <= reg_wdata[SLEEP_TYPE_MSB:SLEEP_TYPE_LSB];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sleep_trap_select <= PSU_CONTROL_RESET[PSU_TRAP_BIT];
      end else if (reg_wr && reg_addr == PSU_CONTROL_ADDR) begin
         sleep_trap_select <= reg_wdata[PSU_TRAP_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         smi_enable_group7 <= SMI_ENABLE_RESET;
      end else if (reg_wr && reg_addr == SMI_ENABLE_ADDR) begin
         smi_enable_group7 <= reg_wdata & ~(8'h01 << STS_RESERVED);
      end
   end

   // Status set and clear vectors
   assign set_vec = {src_rise[5], 1'b0, slp_write, src_rise[4],
      src_rise[3:0]};
   assign clr_vec = wr_sts ? reg_wdata : 8'h00;

   // Status bits, set wins over clear
   for (genvar i = 0; i < 8; i++) begin : g_sts
      always_ff @(posedge core_clk) begin
         if (!rstn) begin
            smi_status_group7[i] <= SMI_STATUS_RESET[i];
         end else if (set_vec[i]) begin
            smi_status_group7[i] <= 1'b1;
         end else if (clr_vec[i]) begin
            smi_status_group7[i] <= 1'b0;
         end
      end
   end

   // Trapped sleep request forces SMI until its flag clears
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         trap_pend <= 1'b0;
      end else if (slp_write && sleep_trap_select) begin
         trap_pend <= 1'b1;
      end else if (wr_sts && reg_wdata[STS_SLEEP_WRITE]) begin
         trap_pend <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         smi_irq <= 1'b0;
      end else begin
         smi_irq <= |(smi_status_group7 & smi_enable_group7)
            || trap_pend;
      end
   end

   // Sleep sequencer
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state <= SESMI_IDLE;
         type_latched <= 3'h0;
      end else begin
         case (state)
            SESMI_IDLE: begin
               if (slp_write && !sleep_trap_select) begin
                  state <= SESMI_WAIT_FIRST;
                  type_latched <= reg_wdata[SLEEP_TYPE_MSB:SLEEP_TYPE_LSB];
               end
            end
            SESMI_WAIT_FIRST: begin
               if (rtc_rise) begin
                  state <= SESMI_WAIT_SECOND;
               end
            end
            SESMI_WAIT_SECOND: begin
               if (rtc_rise) begin
                  state <= SESMI_ASLEEP;
               end
            end
            SESMI_ASLEEP: begin
               state <= SESMI_ASLEEP;
            end
            default: begin
               state <= SESMI_IDLE;
            end
         endcase
      end
   end

   // Sleep outputs
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sleep_state_out <= 3'h0;
         sleeping <= 1'b0;
      end else if (state == SESMI_WAIT_SECOND && rtc_rise) begin
         sleep_state_out <= type_latched;
         sleeping <= 1'b1;
      end
   end

   // Power supply on pin, driven low while on, floated when off
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         power_supply_on_n_out <= 1'b0;
         power_supply_on_n_oe_n <= 1'b0;
      end else begin
         power_supply_on_n_out <= 1'b0;
         if (state == SESMI_WAIT_SECOND && rtc_rise
               && (type_latched == SLEEP_TYPE_S4
               || type_latched == SLEEP_TYPE_S5)) begin
            power_supply_on_n_oe_n <= 1'b1;
         end
      end
   end

   // Read mux
   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == SLEEP_CONTROL_ADDR) begin
            next_rdata[SLEEP_TYPE_MSB:SLEEP_TYPE_LSB] =
               sleep_type_field;
         end else if (reg_addr == SMI_STATUS_ADDR) begin
            next_rdata = smi_status_group7;
         end else if (reg_addr == SMI_ENABLE_ADDR) begin
            next_rdata = smi_enable_group7;
         end else if (reg_addr == PSU_CONTROL_ADDR) begin
            next_rdata[PSU_TRAP_BIT] = sleep_trap_select;
            next_rdata[PSU_PIN_BIT] = pin_s;
            next_rdata[PSU_ASLEEP_BIT] = sleeping;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Helper: core cycles since the accepted sleep write
   logic [31:0] age;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         age <= 32'h0;
      end else if (state == SESMI_IDLE) begin
         age <= 32'h0;
      end else if (state != SESMI_ASLEEP) begin
         age <= age + 32'h1;
      end
   end

   logic rd_ctrl_d;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rd_ctrl_d <= 1'b0;
      end else begin
         rd_ctrl_d <= reg_rd && reg_addr == SLEEP_CONTROL_ADDR;
      end
   end

   sequence arm_s;
      state == SESMI_IDLE && slp_write && !sleep_trap_select;
   endsequence

   sequence second_edge_s;
      state == SESMI_WAIT_SECOND && rtc_rise;
   endsequence

   off_entry_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      second_edge_s ##0 (type_latched[2:1] == 2'b11)
      |=> power_supply_on_n_oe_n && sleeping)
      else $error("soft-off did not float the power pin");

   pin_release_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      $rose(power_supply_on_n_oe_n) |-> !power_supply_on_n_out
      && state == SESMI_ASLEEP)
      else $error("power pin released outside soft-off");

   delay_window_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      $rose(power_supply_on_n_oe_n) |-> age >= MIN_C && age <= MAX_C)
      else $error("release delay outside one to two RTC periods");

   other_type_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      $rose(power_supply_on_n_oe_n) |-> type_latched[2:1] == 2'b11)
      else $error("power pin released for a non-off type");

   ctrl_read_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      rd_ctrl_d |-> reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == 2'h0)
      else $error("sleep control read shows a fixed-zero bit");

   arm_seq_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      arm_s |=> state == SESMI_WAIT_FIRST ##0 !sleeping)
      else $error("sleep write did not start the delay");

   trap_block_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      slp_write && sleep_trap_select && state == SESMI_IDLE
      |=> state == SESMI_IDLE ##1 smi_irq)
      else $error("trapped sleep write did not raise SMI");

   flag_set_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      slp_write |=> sleep_write_smi_flag)
      else $error("sleep write flag not set");

   zero_write_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      wr_ctrl && !reg_wdata[SLEEP_ENABLE_BIT]
      |=> (state == $past(state) || $past(rtc_rise))
      && !$rose(sleep_write_smi_flag))
      else $error("zero enable write had an effect");

   status_clear_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      wr_sts |=> (smi_status_group7 & $past(reg_wdata)
      & ~$past(set_vec)) == 8'h00)
      else $error("status bit not cleared by writing one");

   status_layout_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      src_rise[5] |=> smi_status_group7[STS_GPIO62]
      && !smi_status_group7[STS_RESERVED])
      else $error("status layout broken");

   irq_gate_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      ##1 smi_irq == ($past(|(smi_status_group7 & smi_enable_group7))
      || $past(trap_pend)))
      else $error("SMI output not gated by enables");
endmodule

// *** hw/sesmi_pkg.sv ***
// Constants of the sleep entry and SMI status block.
// Assumes an 8-bit register port and a 100 MHz core clock.
package sesmi_pkg;
   // Register offsets
   localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'h61;
   localparam logic [7:0] SMI_STATUS_ADDR = 8'h64;
   localparam logic [7:0] SMI_ENABLE_ADDR = 8'h66;
   localparam logic [7:0] PSU_CONTROL_ADDR = 8'h68;

   // Sleep control fields
   localparam int SLEEP_TYPE_LSB = 2;
   localparam int SLEEP_TYPE_MSB = 4;
   localparam int SLEEP_ENABLE_BIT = 5;
   localparam logic [2:0] SLEEP_TYPE_S4 = 3'h6;
   localparam logic [2:0] SLEEP_TYPE_S5 = 3'h7;

   // Status and enable layout
   localparam int STS_GPIO34 = 0;
   localparam int STS_KBD = 4;
   localparam int STS_SLEEP_WRITE = 5;
   localparam int STS_RESERVED = 6;
   localparam int STS_GPIO62 = 7;

   // Power supply control fields
   localparam int PSU_TRAP_BIT = 0;
   localparam int PSU_PIN_BIT = 1;
   localparam int PSU_ASLEEP_BIT = 2;

   // Reset values
   localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
   localparam logic [7:0] SMI_STATUS_RESET = 8'h00;
   localparam logic [7:0] SMI_ENABLE_RESET = 8'h00;
   localparam logic [7:0] PSU_CONTROL_RESET = 8'h00;

   // Timing
   localparam int CORE_PERIOD_PS = 10000;
   localparam int RTC_PERIOD_PS = 31250000;
   localparam int SYNC_SLACK_CYCLES = 4;
   localparam int RTC_MIN_CYCLES = (RTC_PERIOD_PS + CORE_PERIOD_PS - 1)
      / CORE_PERIOD_PS;
   localparam int RTC_MAX_CYCLES = (2 * RTC_PERIOD_PS) / CORE_PERIOD_PS;

   // Sleep sequencer
   typedef enum logic [1:0] {
      SESMI_IDLE,
      SESMI_WAIT_FIRST,
      SESMI_WAIT_SECOND,
      SESMI_ASLEEP
   } sesmi_state_type;
endpackage

// *** hw/sesmi_sync.sv ***
// Two-stage level synchroniser for a group of pins.
// Assumes inputs are asynchronous to core_clk.
module sesmi_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   initial begin
      if (WIDTH < 1) $error("sesmi_sync: WIDTH must be positive");
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// *** tb/sesmi_psu_model.sv ***
// Power supply model hanging on the open drain supply-on pin.
// Assumes a pull-up on the pin and the core clock for its own timing.
module sesmi_psu_model (
   // Clock
   input wire logic core_clk,
   // Pin drive from the device
   input wire logic pin_out,
   input wire logic pin_oe_n,
   // Pin level and supply state
   output logic pin_level,
   output logic supply_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-up wins while the device floats the pin
   assign pin_level = pin_oe_n ? 1'b1 : pin_out;
   // Supply follows the pin one cycle later
   always @(posedge core_clk) begin
      supply_on <= !pin_level;
   end
endmodule

// *** tb/sesmi_top_test.sv ***
// Self-checking bench of the sleep entry and SMI status block.
// Assumes a 10-cycle RTC period so the release delay stays short.
module sesmi_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sesmi_pkg::*;
   localparam int RTC_CYC = 10;
   logic core_clk, rstn, reg_wr, reg_rd, rtc_clk_32k;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic [5:0] src_pins;
   logic pin_out, pin_oe_n, pin_level, supply_on, sleeping, smi_irq;
   logic [2:0] sleep_state_out;
   int failures, samples_checked, cycles;

   sesmi_top #(.RTC_MIN(RTC_CYC), .RTC_MAX(2 * RTC_CYC)) u_sesmi_top (
      .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rtc_clk_32k(rtc_clk_32k),
      .gpio_pin_34(src_pins[0]), .gpio_pin_35(src_pins[1]),
      .gpio_pin_36(src_pins[2]), .gpio_pin_37(src_pins[3]),
      .keyboard_port_pin(src_pins[4]), .gpio_pin_62(src_pins[5]),
      .power_supply_on_n_in(pin_level), .power_supply_on_n_out(pin_out),
      .power_supply_on_n_oe_n(pin_oe_n), .sleep_state_out(sleep_state_out),
      .sleeping(sleeping), .smi_irq(smi_irq));

   sesmi_psu_model u_sesmi_psu_model (.core_clk(core_clk),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level),
      .supply_on(supply_on));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // RTC out of phase with the core clock
   initial begin
      rtc_clk_32k = 1'b0;
      #3;
      forever #(RTC_CYC * 5) rtc_clk_32k = ~rtc_clk_32k;
   end

   task automatic complete_run;
      if (failures == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         $display("[FAIL] %0t timeout", $time);
         complete_run;
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp,
         input string msg);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic do_reset;
      @(posedge core_clk);
      rstn <= 1'b0;
      src_pins <= 6'h00;
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      wait_cyc(1);
   endtask

   task automatic test_reset_map;
      do_reset;
      reg_read(SMI_STATUS_ADDR);
      check(rd, 8'h00, "status reset");
      reg_read(SLEEP_CONTROL_ADDR);
      check(rd, 8'h00, "control reset");
      reg_read(SMI_ENABLE_ADDR);
      check(rd, 8'h00, "enable reset");
      reg_read(8'h70);
      check(rd, 8'h00, "unmapped read");
      check({6'h00, pin_oe_n, pin_out}, 8'h00, "pin after reset");
   endtask

   task automatic test_control_bits;
      reg_write(SLEEP_CONTROL_ADDR, 8'hDF);
      reg_read(SLEEP_CONTROL_ADDR);
      check(rd, 8'h1C, "control read mask");
      reg_read(SMI_STATUS_ADDR);
      check(rd, 8'h00, "zero enable sets flag");
      wait_cyc(3 * RTC_CYC);
      check({7'h00, sleeping}, 8'h00, "zero enable sleeps");
      check({7'h00, pin_oe_n}, 8'h00, "zero enable pin");
   endtask

   task automatic test_sources;
      int bits [6] = '{0, 1, 2, 3, 4, 7};
      logic [7:0] m;
      reg_write(SMI_ENABLE_ADDR, 8'hFF);
      reg_read(SMI_ENABLE_ADDR);
      check(rd, 8'hBF, "enable readback");
      for (int i = 0; i < 6; i++) begin
         m = 8'h01 << bits[i];
         @(posedge core_clk);
         src_pins[i] <= 1'b1;
         wait_cyc(6);
         reg_read(SMI_STATUS_ADDR);
         check(rd, m, "source status bit");
         check({7'h00, smi_irq}, 8'h01, "enabled source irq");
         reg_write(SMI_STATUS_ADDR, ~m);
         reg_read(SMI_STATUS_ADDR);
         check(rd, m, "write zero keeps");
         reg_write(SMI_STATUS_ADDR, m);
         reg_read(SMI_STATUS_ADDR);
         check(rd, 8'h00, "write one clears");
         @(posedge core_clk);
         src_pins[i] <= 1'b0;
         wait_cyc(4);
         check({7'h00, smi_irq}, 8'h00, "irq after clear");
      end
      reg_write(SMI_ENABLE_ADDR, 8'h00);
      src_pins[0] <= 1'b1;
      wait_cyc(6);
      reg_read(SMI_STATUS_ADDR);
      check(rd, 8'h01, "masked source status");
      check({7'h00, smi_irq}, 8'h00, "masked source irq");
   endtask

   task automatic test_trap;
      do_reset;
      reg_write(PSU_CONTROL_ADDR, 8'h01);
      reg_write(SLEEP_CONTROL_ADDR, 8'h3C);
      reg_read(SMI_STATUS_ADDR);
      check(rd, 8'h20, "trap sets flag");
      wait_cyc(3 * RTC_CYC);
      check({7'h00, sleeping}, 8'h00, "trap no sleep");
      check({7'h00, pin_oe_n}, 8'h00, "trap keeps supply");
      check({7'h00, smi_irq}, 8'h01, "trap raises smi");
      reg_read(PSU_CONTROL_ADDR);
      check(rd, 8'h01, "trap psu status");
      reg_write(SMI_STATUS_ADDR, 8'h20);
      wait_cyc(3);
      check({7'h00, smi_irq}, 8'h00, "trap smi cleared");
   endtask

   task automatic test_sleep(input logic [2:0] t);
      int n;
      logic off;
      logic in_window;
      off = (t == SLEEP_TYPE_S4) || (t == SLEEP_TYPE_S5);
      do_reset;
      reg_write(SLEEP_CONTROL_ADDR, {3'h1, t, 2'h0});
      n = 0;
      while (sleeping !== 1'b1 && n < 60) begin
         wait_cyc(1);
         n++;
      end
      in_window = n >= RTC_CYC && n <= 2 * RTC_CYC + SYNC_SLACK_CYCLES;
      check({7'h00, in_window}, 8'h01, "release delay");
      check({5'h00, sleep_state_out}, {5'h00, t}, "sleep type");
      check({7'h00, pin_oe_n}, {7'h00, off}, "pin float");
      wait_cyc(1);
      check({7'h00, supply_on}, {7'h00, !off}, "supply");
      reg_read(SMI_STATUS_ADDR);
      check(rd, 8'h20, "sleep write flag");
      reg_read(PSU_CONTROL_ADDR);
      check(rd, {5'h00, 1'b1, off, 1'b0}, "psu status");
      reg_read(SLEEP_CONTROL_ADDR);
      check(rd, {3'h0, t, 2'h0}, "enable reads zero");
      reg_write(SLEEP_CONTROL_ADDR, 8'h20);
      wait_cyc(3 * RTC_CYC);
      check({5'h00, sleep_state_out}, {5'h00, t}, "second write");
   endtask

   initial begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      src_pins = 6'h00;
      failures = 0;
      samples_checked = 0;
      cycles = 0;
      test_reset_map;
      test_control_bits;
      test_sources;
      test_trap;
      for (int t = 0; t < 8; t++) begin
         test_sleep(t[2:0]);
      end
      complete_run;
   end
endmodule
